//--- hdl/tfc_pkg.sv
// Constants and types of the fan and over-temperature configuration bank.
// Assumes one 10 MHz clock and a plain byte-wide register port.
//
// What this block does
// - Hold an 8-bit assertion limit in steps of 22.76 ms.
// - In fourth-input mode, assertion time beyond the limit sets bit 5 of interrupt status 0x42.
// - A zero limit raises the interrupt at once on input assertion.
// - Four 2-bit pulse-count selects, fan 1 lowest, reset value 0x55.
// - Config 4 bit 0 set makes the shared pin an alert output.
// - Config 4 bits 3:2 hold the two-wire input threshold code.
// - With the lock bit set, writes to config 4 are ignored.
// - Assertion flag sets on input assertion, clears on read, becomes timer LSB.
// - In fourth-input mode, fan 4 mask bit masks the timer event.
package tfc_pkg;
  localparam logic [7:0] CFG1_OFS      = 8'h40;
  localparam logic [7:0] INT_STAT_OFS  = 8'h42;
  localparam logic [7:0] INT_MASK_OFS  = 8'h74;
  localparam logic [7:0] OT_STAT_OFS   = 8'h79;
  localparam logic [7:0] LIMIT_OFS     = 8'h7a;
  localparam logic [7:0] PULSE_OFS     = 8'h7b;
  localparam logic [7:0] CFG4_OFS      = 8'h7d;
  localparam logic [7:0] TEST1_OFS     = 8'h7e;
  localparam logic [7:0] TEST2_OFS     = 8'h7f;
  localparam logic [7:0] LIMIT_RST     = 8'h00;
  localparam logic [7:0] PULSE_RST     = 8'h55;
  localparam logic [7:0] CFG4_RST      = 8'h00;
  localparam logic [7:0] CFG1_RST      = 8'h00;
  localparam logic [7:0] MASK_RST      = 8'h00;
  localparam logic [7:0] TEST_RST      = 8'h00;
  localparam int         LOCK_BIT      = 1;
  localparam int         FOURTH_SPEED_INPUT_OT_BIT  = 2;
  localparam int         TIMER_EV_BIT  = 5;
  localparam int         ALERT_SEL_BIT = 0;
  localparam int         THR_LSB       = 2;
  localparam logic [7:0] CFG4_WMASK    = 8'h0d;
  localparam logic [7:0] CFG1_WMASK    = 8'h06;
  localparam int         STEP_NS       = 22760000;
  localparam int         CLK_NS        = 100;
  localparam int         STEP_CYCLES   = STEP_NS / CLK_NS;
  localparam int         FLAG_STEPS    = 2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tfc_bus_type;
endpackage

//--- hdl/tfc_regs.sv
// Configuration bank with over-temperature assertion timer and alert.
// Assumes the bus master is on clk_i; the over-temperature pin is asynchronous.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tfc_regs
  import tfc_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Register port
  input  wire tfc_bus_type bus_i,
  output logic [7:0]       rdata_o,
  // Pins and events
  input  wire logic        overtemp_input_n_i,
  input  wire logic        fan_four_pulse_select_fault_i,
  // Configuration out
  output logic [7:0]       fan_pulse_sel_o,
  output logic [1:0]       two_wire_threshold_code_o,
  output logic             shared_pin_alert_select_o,
  output logic             fourth_speed_input_ot_o,
  // Alert
  output logic             irq_o,
  output logic             shared_pin_o,
  output logic             shared_pin_oe_o
);

  logic [7:0]  assert_limit_value;
  logic [7:0]  pulse_sel;
  logic [7:0]  cfg4;
  logic [7:0]  cfg1;
  logic [7:0]  int_stat;
  logic [7:0]  int_mask;
  logic [7:0]  assert_duration_count;
  logic        assert_flag_timer_lsb;
  logic        fired;
  logic [17:0] step_cnt;
  logic [7:0]  rdata;
  logic        ot_meta;
  logic        ot_sync;
  logic        ot_prev;

  logic [7:0]  next_limit;
  logic [7:0]  next_pulse_sel;
  logic [7:0]  next_cfg4;
  logic [7:0]  next_cfg1;
  logic [7:0]  next_int_stat;
  logic [7:0]  next_int_mask;
  logic [7:0]  next_count;
  logic        next_flag;
  logic        next_fired;
  logic [17:0] next_step_cnt;
  logic [7:0]  next_rdata;

  logic        ot_rise;
  logic        step;
  logic        timer_event;
  logic        lock;
  logic        fourth_speed_input_mode;
  logic [7:0]  ot_stat_view;

  function automatic logic hit(input tfc_bus_type b, input logic [7:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction

  // Pin synchroniser, first stage read only by second
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ot_meta <= 1'b0;
      ot_sync <= 1'b0;
      ot_prev <= 1'b0;
    end else begin
      ot_meta <= ~overtemp_input_n_i;
      ot_sync <= ot_meta;
      ot_prev <= ot_sync;
    end
  end

  assign ot_rise    = ot_sync && !ot_prev;
  assign lock       = cfg1[LOCK_BIT];
  assign fourth_speed_input_mode = cfg1[FOURTH_SPEED_INPUT_OT_BIT];
  assign step       = ot_sync && (step_cnt == 18'(STEP_CYC - 1));

  // Timer LSB merges with the flag once two steps have passed
  always_comb begin
    if (assert_duration_count >= 8'(FLAG_STEPS)) begin
      ot_stat_view = {assert_duration_count[7:1], 1'b1};
    end else begin
      ot_stat_view = {7'h00, assert_flag_timer_lsb};
    end
  end

  always_comb begin
    next_step_cnt = step_cnt;
    next_count    = assert_duration_count;
    next_flag     = assert_flag_timer_lsb;
    next_fired    = fired;
    timer_event   = 1'b0;
    if (!ot_sync) begin
      next_step_cnt = 18'h00000;
      next_fired    = 1'b0;
    end else if (step) begin
      next_step_cnt = 18'h00000;
    end else begin
      next_step_cnt = step_cnt + 18'h00001;
    end
    if (step && assert_duration_count != 8'hff) begin
      next_count = assert_duration_count + 8'h01;
    end
    if (bus_i.rd && bus_i.addr == OT_STAT_OFS) begin
      next_flag  = 1'b0;
      next_count = 8'h00;
    end
    if (ot_rise) begin
      next_flag = 1'b1;
    end
    if (ot_rise && assert_limit_value == 8'h00) begin
      timer_event = 1'b1;
      next_fired  = 1'b1;
    end else if (step && !fired && (assert_duration_count + 8'h01) > assert_limit_value) begin
      timer_event = assert_duration_count != 8'hff;
      next_fired  = 1'b1;
    end
  end

  always_comb begin
    next_limit     = assert_limit_value;
    next_pulse_sel = pulse_sel;
    next_cfg4      = cfg4;
    next_cfg1      = cfg1;
    next_int_mask  = int_mask;
    next_int_stat  = int_stat;
    if (hit(bus_i, LIMIT_OFS)) begin
      next_limit = bus_i.wdata;
    end
    if (hit(bus_i, PULSE_OFS)) begin
      next_pulse_sel = bus_i.wdata;
    end
    if (hit(bus_i, CFG4_OFS) && !lock) begin
      next_cfg4 = bus_i.wdata & CFG4_WMASK;
    end
    if (hit(bus_i, CFG1_OFS)) begin
      next_cfg1 = (bus_i.wdata & CFG1_WMASK) | (cfg1 & (8'h01 << LOCK_BIT));
    end
    if (hit(bus_i, INT_MASK_OFS)) begin
      next_int_mask = bus_i.wdata;
    end
    if (hit(bus_i, INT_STAT_OFS)) begin
      next_int_stat = int_stat & ~bus_i.wdata;
    end
    // Set wins over a same-cycle clear
    if ((fourth_speed_input_mode && timer_event) || (!fourth_speed_input_mode && fan_four_pulse_select_fault_i)) begin
      next_int_stat[TIMER_EV_BIT] = 1'b1;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (bus_i.rd) begin
      case (bus_i.addr)
        CFG1_OFS:     next_rdata = cfg1;
        INT_STAT_OFS: next_rdata = int_stat;
        INT_MASK_OFS: next_rdata = int_mask;
        OT_STAT_OFS:  next_rdata = ot_stat_view;
        LIMIT_OFS:    next_rdata = assert_limit_value;
        PULSE_OFS:    next_rdata = pulse_sel;
        CFG4_OFS:     next_rdata = cfg4;
        TEST1_OFS:    next_rdata = TEST_RST;
        TEST2_OFS:    next_rdata = TEST_RST;
        default:      next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      assert_limit_value    <= LIMIT_RST;
      pulse_sel             <= PULSE_RST;
      cfg4                  <= CFG4_RST;
      cfg1                  <= CFG1_RST;
      int_stat              <= 8'h00;
      int_mask              <= MASK_RST;
      assert_duration_count <= 8'h00;
      assert_flag_timer_lsb <= 1'b0;
      fired                 <= 1'b0;
      step_cnt              <= 18'h00000;
      rdata                 <= 8'h00;
    end else begin
      assert_limit_value    <= next_limit;
      pulse_sel             <= next_pulse_sel;
      cfg4                  <= next_cfg4;
      cfg1                  <= next_cfg1;
      int_stat              <= next_int_stat;
      int_mask              <= next_int_mask;
      assert_duration_count <= next_count;
      assert_flag_timer_lsb <= next_flag;
      fired                 <= next_fired;
      step_cnt              <= next_step_cnt;
      rdata                 <= next_rdata;
    end
  end

  assign rdata_o                   = rdata;
  assign fan_pulse_sel_o           = pulse_sel;
  assign two_wire_threshold_code_o = cfg4[THR_LSB +: 2];
  assign shared_pin_alert_select_o = cfg4[ALERT_SEL_BIT];
  assign fourth_speed_input_ot_o   = fourth_speed_input_mode;
  assign irq_o                     = |(int_stat & ~int_mask);
  // Open-drain alert, pulled low while active
  assign shared_pin_o              = 1'b0;
  assign shared_pin_oe_o           = irq_o && cfg4[ALERT_SEL_BIT];

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  limit_write_a: assert property (hit(bus_i, LIMIT_OFS) |=>
    assert_limit_value == $past(bus_i.wdata))
    else $error("limit not stored");

  limit_hold_a: assert property (!hit(bus_i, LIMIT_OFS) |=>
    $stable(assert_limit_value))
    else $error("limit changed without write");

  timer_status_a: assert property (fourth_speed_input_mode && timer_event |=> int_stat[TIMER_EV_BIT])
    else $error("timer event lost");

  zero_limit_a: assert property (fourth_speed_input_mode && ot_rise && assert_limit_value == 8'h00
    |=> int_stat[TIMER_EV_BIT])
    else $error("zero limit not immediate");

  pulse_write_a: assert property (hit(bus_i, PULSE_OFS) |=>
    fan_pulse_sel_o == $past(bus_i.wdata))
    else $error("pulse select wrong");

  pin_mode_a: assert property (shared_pin_oe_o |-> shared_pin_alert_select_o && irq_o)
    else $error("pin driven in input mode");

  pin_low_a: assert property (shared_pin_o == 1'b0)
    else $error("alert pin driven high");

  thr_code_a: assert property (hit(bus_i, CFG4_OFS) && !lock |=>
    two_wire_threshold_code_o == $past(bus_i.wdata[3:2]))
    else $error("threshold code wrong");

  res_bits_a: assert property ((cfg4 & ~CFG4_WMASK) == 8'h00)
    else $error("reserved config bit set");

  lock_hold_a: assert property (lock && hit(bus_i, CFG4_OFS) |=> $stable(cfg4))
    else $error("locked write took effect");

  lock_sticky_a: assert property (lock |=> lock)
    else $error("lock bit dropped");

  test_zero_a: assert property (bus_i.rd && bus_i.addr == TEST2_OFS |=> rdata_o == 8'h00)
    else $error("test register nonzero");

  rd_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside answer cycle");

  flag_set_a: assert property (ot_rise |=> assert_flag_timer_lsb ##1
    (assert_flag_timer_lsb || $past(bus_i.rd && bus_i.addr == OT_STAT_OFS)))
    else $error("assertion flag missing");

  count_hold_a: assert property (!step && !(bus_i.rd && bus_i.addr == OT_STAT_OFS) |=>
    $stable(assert_duration_count))
    else $error("count moved without step");

  mask_gate_a: assert property (int_mask[TIMER_EV_BIT] && int_stat == 8'h20 |-> !irq_o)
    else $error("masked event reached alert");

  fan_four_pulse_select_gate_a: assert property (fourth_speed_input_mode && !timer_event && !int_stat[TIMER_EV_BIT] |=>
    !int_stat[TIMER_EV_BIT])
    else $error("fan fault set bit in timer mode");

  no_early_a: assert property (timer_event && assert_limit_value != 8'h00 |->
    step && assert_duration_count >= assert_limit_value)
    else $error("event before limit");

  one_shot_a: assert property (fired && ot_sync |-> !timer_event)
    else $error("second event in one assertion");

  ev_seen_c: cover property (fourth_speed_input_mode && timer_event ##1 irq_o);

  lock_try_c: cover property (lock && hit(bus_i, CFG4_OFS));

  alert_drv_c: cover property (shared_pin_oe_o);

  fan_four_pulse_select_ev_c: cover property (!fourth_speed_input_mode && fan_four_pulse_select_fault_i);

  limit_hit_c: cover property (step && timer_event);

endmodule
`default_nettype wire

//--- tb/tfc_host.sv
// Host model: master of the byte-wide register port.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module tfc_host
  import tfc_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Register port
  output var tfc_bus_type bus_o,
  input  wire logic [7:0] rdata_i
);
  initial bus_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus_o <= '0;
  endtask
  // Read data stand only in the cycle after the strobe: take them mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bus_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    bus_o <= '0;
    @(negedge clk_i);
    d = rdata_i;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- tb/tfc_regs_tb.sv
// Self-checking bench of the fan and over-temperature configuration bank.
// Assumes the host model drives the register port; test registers are only read.
`timescale 1ns/100ps
`default_nettype none
module tfc_regs_tb;
  import tfc_pkg::*;
  localparam int STEP = 8;
  logic        clk_i;
  logic        arst_n_i;
  tfc_bus_type bus;
  logic [7:0]  rdata;
  logic        ot_n;
  logic [7:0]  pulse_sel;
  logic [1:0]  thr;
  logic        alert_sel;
  logic        ot_mode;
  logic        irq;
  logic        pin_oe;
  logic        pin_lvl;
  logic        fan_four_pulse_select;
  logic [7:0]  v;
  int          errors;
  int          cmp_count;
  logic [7:0]  ofs [6] = '{LIMIT_OFS, PULSE_OFS, CFG4_OFS, TEST1_OFS, TEST2_OFS, 8'h00};
  logic [7:0]  rst [6] = '{LIMIT_RST, PULSE_RST, CFG4_RST, TEST_RST, TEST_RST, 8'h00};
  logic [7:0]  pv [2]  = '{8'h1b, 8'he4};

  tfc_regs #(.STEP_CYC(STEP)) u_tfc_regs (
    .clk_i                     (clk_i),
    .arst_n_i                  (arst_n_i),
    .bus_i                     (bus),
    .rdata_o                   (rdata),
    .overtemp_input_n_i        (ot_n),
    .fan_four_pulse_select_fault_i              (fan_four_pulse_select),
    .fan_pulse_sel_o           (pulse_sel),
    .two_wire_threshold_code_o (thr),
    .shared_pin_alert_select_o (alert_sel),
    .fourth_speed_input_ot_o   (ot_mode),
    .irq_o                     (irq),
    .shared_pin_o              (pin_lvl),
    .shared_pin_oe_o           (pin_oe)
  );
  tfc_host u_tfc_host (.clk_i(clk_i), .bus_o(bus), .rdata_i(rdata));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++) @(negedge clk_i);
  endtask
  task automatic wrap_up;
    $display("comparisons=%0d mismatches=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    errors++;
    wrap_up();
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    arst_n_i = 1'b0;
    ot_n = 1'b1;
    fan_four_pulse_select = 1'b0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    chk(pulse_sel, PULSE_RST);
    // Reset values, test registers and an unmapped place
    for (int i = 0; i < 6; i++) begin
      u_tfc_host.rd(ofs[i], v);
      chk(v, rst[i]);
    end
    u_tfc_host.wr(LIMIT_OFS, 8'hff);
    u_tfc_host.rd(LIMIT_OFS, v);
    chk(v, 8'hff);
    for (int i = 0; i < 2; i++) begin
      u_tfc_host.wr(PULSE_OFS, pv[i]);
      @(negedge clk_i);
      chk(pulse_sel, pv[i]);
      u_tfc_host.rd(PULSE_OFS, v);
      chk(v, pv[i]);
    end
    // Reserved bits written high must read back zero
    for (int c = 0; c < 4; c++) begin
      u_tfc_host.wr(CFG4_OFS, 8'hf2 | 8'(c << 2) | 8'(c & 1));
      @(negedge clk_i);
      chk(8'(thr), 8'(c));
      chk(8'(alert_sel), 8'(c & 1));
      u_tfc_host.rd(CFG4_OFS, v);
      chk(v, 8'(c << 2) | 8'(c & 1));
    end
    // Fan 4 fault reaches bit 5 while the fourth input is a speed input
    fan_four_pulse_select <= 1'b1;
    @(posedge clk_i);
    fan_four_pulse_select <= 1'b0;
    u_tfc_host.rd(INT_STAT_OFS, v);
    chk(v, 8'h20);
    u_tfc_host.wr(INT_STAT_OFS, 8'h20);
    u_tfc_host.wr(CFG1_OFS, 8'h06);
    u_tfc_host.wr(CFG4_OFS, 8'h00);
    u_tfc_host.rd(CFG4_OFS, v);
    chk(v, 8'h0d);
    chk(8'(alert_sel), 8'h01);
    chk(8'(ot_mode), 8'h01);
    // Zero limit: event as soon as the input asserts
    u_tfc_host.wr(LIMIT_OFS, 8'h00);
    u_tfc_host.wr(INT_MASK_OFS, 8'h00);
    ot_n <= 1'b0;
    wait_irq(6);
    chk(8'(irq), 8'h01);
    chk(8'(pin_oe), 8'h01);
    chk(8'(pin_lvl), 8'h00);
    u_tfc_host.rd(INT_STAT_OFS, v);
    chk(v, 8'h20);
    u_tfc_host.rd(OT_STAT_OFS, v);
    chk(v & 8'h01, 8'h01);
    ot_n <= 1'b1;
    u_tfc_host.wr(INT_STAT_OFS, 8'h20);
    @(negedge clk_i);
    chk(8'(irq), 8'h00);
    u_tfc_host.rd(OT_STAT_OFS, v);
    // Limit of two steps, event masked first
    u_tfc_host.wr(LIMIT_OFS, 8'h02);
    u_tfc_host.wr(INT_MASK_OFS, 8'h20);
    ot_n <= 1'b0;
    repeat (2 * STEP + 4) @(posedge clk_i);
    u_tfc_host.rd(INT_STAT_OFS, v);
    chk(v, 8'h00);
    repeat (2 * STEP) @(posedge clk_i);
    chk(8'(irq), 8'h00);
    u_tfc_host.rd(INT_STAT_OFS, v);
    chk(v, 8'h20);
    u_tfc_host.wr(INT_MASK_OFS, 8'h00);
    @(negedge clk_i);
    chk(8'(irq), 8'h01);
    u_tfc_host.rd(OT_STAT_OFS, v);
    chk(8'(v[7:1] != 7'h00), 8'h01);
    chk(v & 8'h01, 8'h01);
    ot_n <= 1'b1;
    u_tfc_host.wr(INT_STAT_OFS, 8'h20);
    @(negedge clk_i);
    chk(8'(irq), 8'h00);
    // In fourth-input mode a fan 4 fault no longer sets bit 5
    @(posedge clk_i);
    fan_four_pulse_select <= 1'b1;
    @(posedge clk_i);
    fan_four_pulse_select <= 1'b0;
    u_tfc_host.rd(INT_STAT_OFS, v);
    chk(v, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
